// file: adcbs_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the scan control block
// Assumes: Byte addresses on the register bus, one 32-bit word per register
// Notes: Definitions only
`ifndef ADCBS_MAP_SVH
`define ADCBS_MAP_SVH

`define ADCBS_REG_CTRL 5'h00
`define ADCBS_REG_FUNC_LO 5'h04
`define ADCBS_REG_FUNC_HI 5'h08
`define ADCBS_REG_STATUS 5'h0c
`define ADCBS_REG_APPL_LO 5'h10
`define ADCBS_REG_APPL_HI 5'h14

`define ADCBS_CTRL_SCAN_BIT 0
`define ADCBS_STAT_CMP_BIT 0
`define ADCBS_STAT_BUSY_BIT 1
`define ADCBS_STAT_READY_BIT 2
`define ADCBS_STAT_SCAN_BIT 3

`define ADCBS_CTRL_W 35
`define ADCBS_CHAIN_W 36
`define ADCBS_CMP_POS 35

// Idle pattern: DAC at midpoint, bypass, hold, input 0, pass gate, no precharge
`define ADCBS_CTRL_RST {5'h00, 10'h200, 6'h22, 8'h01, 3'h0, 3'h6}

`define ADCBS_DUMMY_CMPS 10
`define ADCBS_SETTLE_NS 200
`define ADCBS_CLK_NS 100
`define ADCBS_SETTLE_CYC ((`ADCBS_SETTLE_NS + `ADCBS_CLK_NS - 1) / `ADCBS_CLK_NS)

`endif

// file: adcbs_pkg.sv
// Purpose: Types shared by the scan control block
// Assumes: Field order of the control word follows the scan order, highest first
// Notes: None
`default_nettype none
package adcbs_pkg;

    typedef struct packed {
        logic aclk;
        logic gain_path_to_cmp_en;
        logic bandgap_neg_input_en;
        logic converter_power_on;
        logic gain_stage_power_on;
        logic [9:0] dac_code;
        logic gain_bypass_en;
        logic gain_x10_en;
        logic gain_x20_en;
        logic neg_input_ground_en;
        logic hold;
        logic bandgap_dac_ref_en;
        logic [7:0] input_select;
        logic [2:0] neg_select;
        logic gain_passgate_en;
        logic cmp_latch_precharge_n;
        logic switchcap_test_en;
    } adcbs_ctrl_s;

    typedef struct packed {
        logic tck;
        logic tdi;
        logic capture;
        logic shift;
        logic update;
        logic cmp;
    } adcbs_tap_s;

    typedef enum logic [1:0] {
        CONV_OFF,
        CONV_DUMMY,
        CONV_SETTLE,
        CONV_READY
    } adcbs_conv_e;

endpackage
`default_nettype wire

// file: adcbs_scan_ctrl.sv
// Purpose: Scan cells and register control of the converter's analog control lines
// Assumes: Test clock and scan strobes are slow pins, sampled by CLK_SYS
// Notes: Scan mode lets the update latches drive the converter, else registers do
//
// How it works
// - Comparator result is captured into the chain; reads 0 while converter unpowered.
// - Analog clock line clocks gain stages; idles at 0.
// - Gain-path enable joins gain-stage output to comparator; idles at 0.
// - Band-gap enable feeds comparator negative input; idles at 0.
// - Converter power-on powers converter when set; idles at 0.
// - Gain-stage power-on powers the gain stages; idles at 0.
// - Bypass routes channels 0 to 3 around gain stages; idles at 1.
// - Ground enable ties comparator negative input to ground; idles at 0.
// - Hold low samples, high holds; idles at 1.
// - Reference enable selects band-gap as DAC reference; idles at 0.
// - Three-bit negative-input selector for differential measurement; idles at 0.
// - Pass-gate enable for gain stages; idles at 1.
// - Active-low precharge of comparator latch; idles at 1.
// - Switched-cap test routes tenfold stage to converter input 4 pin; idles 0.
// - Power-on in normal mode runs ten dummy comparisons, then waits 200 ns.
`timescale 1ns/10ps
`default_nettype none
`include "adcbs_map.svh"
module adcbs_scan_ctrl
    import adcbs_pkg::*;
#(
    parameter int CMP_DIV = 1,
    parameter int SETTLE_CYC = `ADCBS_SETTLE_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic TAP_TCK,
    input wire logic TAP_TDI,
    input wire logic TAP_CAPTURE,
    input wire logic TAP_SHIFT,
    input wire logic TAP_UPDATE,
    output logic TAP_TDO,
    input wire logic CMP_RESULT,
    output var adcbs_ctrl_s ADC_CTRL,
    output logic ADC_READY,
    output logic CMP_OBSERVED
);

    adcbs_tap_s tap_raw;
    adcbs_tap_s tap_s;
    logic tck_d;
    logic tck_rise;
    logic tck_fall;
    logic [`ADCBS_CHAIN_W-1:0] shift_reg;
    adcbs_ctrl_s upd;
    adcbs_ctrl_s func;
    adcbs_ctrl_s src;
    adcbs_ctrl_s next_ctrl;
    logic [`ADCBS_CTRL_W-1:0] func_bits;
    logic [`ADCBS_CTRL_W-1:0] appl_bits;
    logic scan_mode;
    logic wr_fire;
    logic [31:0] lo_merged;
    logic [31:0] hi_merged;
    logic [31:0] rd_mux;
    adcbs_conv_e conv_state;
    adcbs_conv_e next_state;
    logic pwr_d;
    logic pwr_rise;
    logic [7:0] div_cnt;
    logic cmp_en;
    logic [3:0] cmp_cnt;
    logic [7:0] settle_cnt;
    logic busy;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign tap_raw = '{tck: TAP_TCK, tdi: TAP_TDI, capture: TAP_CAPTURE,
                       shift: TAP_SHIFT, update: TAP_UPDATE, cmp: CMP_RESULT};

    adcbs_sync #(
        .W($bits(adcbs_tap_s))
    ) u_sync (
        .clk(CLK_SYS),
        .resetn(RESETN),
        .d(tap_raw),
        .q(tap_s)
    );

    // Test clock edges found on the synchronised copy
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tap_s.tck;
        end
    end

    assign tck_rise = tap_s.tck & ~tck_d;
    assign tck_fall = ~tap_s.tck & tck_d;

    // Capture takes the observe bit and the lines as driven now
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            shift_reg <= '0;
        end else if (tck_rise) begin
            if (tap_s.capture) begin
                shift_reg <= {CMP_OBSERVED, ADC_CTRL};
            end else if (tap_s.shift) begin
                shift_reg <= {tap_s.tdi, shift_reg[`ADCBS_CHAIN_W-1:1]};
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            TAP_TDO <= 1'b0;
        end else if (tck_fall) begin
            TAP_TDO <= shift_reg[0];
        end
    end

    // Update cells change on the falling test clock so shifting never glitches them
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            upd <= `ADCBS_CTRL_RST;
        end else if (tck_fall && tap_s.update) begin
            upd <= shift_reg[`ADCBS_CTRL_W-1:0];
        end
    end

    // Register bus: one wait cycle, then the answer
    assign wr_fire = AVS_WRITE & ~AVS_WAITREQUEST;
    assign func_bits = func;
    assign appl_bits = ADC_CTRL;
    assign lo_merged = merge(func_bits[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
    assign hi_merged = merge({29'h0, func_bits[34:32]}, AVS_WRITEDATA, AVS_BYTEENABLE);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0;
        end else if (!AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if (AVS_READ || AVS_WRITE) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA <= rd_mux;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            scan_mode <= 1'b0;
        end else if (wr_fire && AVS_ADDRESS == `ADCBS_REG_CTRL && AVS_BYTEENABLE[0]) begin
            scan_mode <= AVS_WRITEDATA[`ADCBS_CTRL_SCAN_BIT];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            func <= `ADCBS_CTRL_RST;
        end else if (wr_fire && AVS_ADDRESS == `ADCBS_REG_FUNC_LO) begin
            func <= {func_bits[34:32], lo_merged};
        end else if (wr_fire && AVS_ADDRESS == `ADCBS_REG_FUNC_HI) begin
            func <= {hi_merged[2:0], func_bits[31:0]};
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        case (AVS_ADDRESS)
            `ADCBS_REG_CTRL: rd_mux[`ADCBS_CTRL_SCAN_BIT] = scan_mode;
            `ADCBS_REG_FUNC_LO: rd_mux = func_bits[31:0];
            `ADCBS_REG_FUNC_HI: rd_mux = {29'h0, func_bits[34:32]};
            `ADCBS_REG_STATUS: begin
                rd_mux[`ADCBS_STAT_CMP_BIT] = CMP_OBSERVED;
                rd_mux[`ADCBS_STAT_BUSY_BIT] = busy;
                rd_mux[`ADCBS_STAT_READY_BIT] = ADC_READY;
                rd_mux[`ADCBS_STAT_SCAN_BIT] = scan_mode;
            end
            `ADCBS_REG_APPL_LO: rd_mux = appl_bits[31:0];
            `ADCBS_REG_APPL_HI: rd_mux = {29'h0, appl_bits[34:32]};
            default: rd_mux = 32'h0;
        endcase
    end

    // Each field passes straight to its analog line, except the two gain enables, which both drop when both are set
    always_comb begin
        src = scan_mode ? upd : func;
        next_ctrl = src;
        // Both gains at once would short the stages: drop both instead
        if (src.gain_x10_en && src.gain_x20_en) begin
            next_ctrl.gain_x10_en = 1'b0;
            next_ctrl.gain_x20_en = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ADC_CTRL <= `ADCBS_CTRL_RST;
        end else begin
            ADC_CTRL <= next_ctrl;
        end
    end

    // Unpowered comparator reads low
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            CMP_OBSERVED <= 1'b0;
        end else begin
            CMP_OBSERVED <= tap_s.cmp & ADC_CTRL.converter_power_on;
        end
    end

    // Dummy conversion after power-on in normal mode
    assign pwr_rise = ADC_CTRL.converter_power_on & ~pwr_d;
    assign cmp_en = (div_cnt == 8'(CMP_DIV - 1));
    assign busy = (conv_state == CONV_DUMMY) || (conv_state == CONV_SETTLE);

    always_comb begin
        next_state = conv_state;
        unique case (conv_state)
            CONV_OFF: begin
                if (pwr_rise) begin
                    next_state = scan_mode ? CONV_READY : CONV_DUMMY;
                end
            end
            CONV_DUMMY: begin
                if (cmp_en && cmp_cnt == 4'(`ADCBS_DUMMY_CMPS - 1)) begin
                    next_state = CONV_SETTLE;
                end
            end
            CONV_SETTLE: begin
                if (settle_cnt == 8'(SETTLE_CYC - 1)) begin
                    next_state = CONV_READY;
                end
            end
            CONV_READY: begin
                next_state = CONV_READY;
            end
        endcase
        if (!ADC_CTRL.converter_power_on) begin
            next_state = CONV_OFF;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            conv_state <= CONV_OFF;
            ADC_READY <= 1'b0;
            pwr_d <= 1'b0;
        end else begin
            conv_state <= next_state;
            ADC_READY <= (next_state == CONV_READY);
            pwr_d <= ADC_CTRL.converter_power_on;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            div_cnt <= 8'h00;
            cmp_cnt <= 4'h0;
        end else if (conv_state != CONV_DUMMY) begin
            div_cnt <= 8'h00;
            cmp_cnt <= 4'h0;
        end else if (cmp_en) begin
            div_cnt <= 8'h00;
            cmp_cnt <= cmp_cnt + 4'h1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            settle_cnt <= 8'h00;
        end else if (conv_state != CONV_SETTLE) begin
            settle_cnt <= 8'h00;
        end else begin
            settle_cnt <= settle_cnt + 8'h01;
        end
    end

    // Helper: cycles spent in dummy and settle, for the checks below
    logic [7:0] dummy_len;
    logic [7:0] settle_len;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            dummy_len <= 8'h00;
            settle_len <= 8'h00;
        end else begin
            dummy_len <= (conv_state == CONV_DUMMY) ? dummy_len + 8'h01 : 8'h00;
            settle_len <= (conv_state == CONV_SETTLE) ? settle_len + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    AST_CMP_GATED: assert property (
        !ADC_CTRL.converter_power_on |=> !CMP_OBSERVED)
        else $error("Comparator observed high while converter unpowered");

    AST_CAPTURE: assert property (
        (tck_rise && tap_s.capture) |=> shift_reg[`ADCBS_CMP_POS] == $past(CMP_OBSERVED))
        else $error("Capture did not take the comparator bit");

    AST_GAIN_EXCL: assert property (
        !(ADC_CTRL.gain_x10_en && ADC_CTRL.gain_x20_en))
        else $error("Both gain enables driven");

    AST_SCAN_DRIVE: assert property (
        (scan_mode && !(upd.gain_x10_en && upd.gain_x20_en)) |=> ADC_CTRL == $past(upd))
        else $error("Update cells not driven to converter");

    AST_FUNC_DRIVE: assert property (
        (!scan_mode && !(func.gain_x10_en && func.gain_x20_en)) |=> ADC_CTRL == $past(func))
        else $error("Register value not driven to converter");

    AST_UPDATE: assert property (
        (tck_fall && tap_s.update) |=> upd == $past(shift_reg[`ADCBS_CTRL_W-1:0]))
        else $error("Update cells did not take the chain");

    AST_DUMMY_START: assert property (
        (conv_state == CONV_OFF && pwr_rise && !scan_mode) |=> conv_state == CONV_DUMMY)
        else $error("Power-on did not start dummy conversion");

    AST_DUMMY_LEN: assert property (
        (conv_state == CONV_DUMMY && next_state == CONV_SETTLE)
            |-> dummy_len == 8'(`ADCBS_DUMMY_CMPS * CMP_DIV - 1))
        else $error("Dummy conversion length wrong");

    AST_SETTLE: assert property (
        (conv_state == CONV_SETTLE && next_state == CONV_READY)
            |-> settle_len == 8'(SETTLE_CYC - 1) ##1 ADC_READY)
        else $error("Ready raised without the settle wait");

    AST_READY_OFF: assert property (
        !ADC_CTRL.converter_power_on |=> !ADC_READY)
        else $error("Ready while converter unpowered");

    AST_WAIT: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("Bus answer not one cycle after request");

    COV_DUMMY_DONE: cover property (conv_state == CONV_SETTLE ##[1:4] ADC_READY);
    COV_SCAN_UPDATE: cover property (scan_mode && tck_fall && tap_s.update);
    COV_GAIN_CLASH: cover property (src.gain_x10_en && src.gain_x20_en);
    COV_WRITE: cover property (wr_fire && AVS_ADDRESS == `ADCBS_REG_FUNC_LO);

endmodule
`default_nettype wire

// file: adcbs_sync.sv
// Purpose: Two-stage synchroniser for inputs from outside the system clock
// Assumes: Each bit is an independent level
// Notes: First stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none
module adcbs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// file: adcbs_tap_model.sv
// Purpose: Scan test controller model driving the converter's scan cells
// Assumes: Test clock of 800 ns, four system clocks high and four low
// Notes: Test clock stands still at 0 between frames
`timescale 1ns/10ps
`default_nettype none
module adcbs_tap_model
    import adcbs_pkg::*;
(
    input wire logic clk,
    output logic tck,
    output logic tdi,
    output logic capture,
    output logic shift,
    output logic update,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tdi = 1'b1;
        capture = 1'b0;
        shift = 1'b0;
        update = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse;
        tick(1);
        tck <= 1'b1;
        tick(4);
        tck <= 1'b0;
        tick(3);
    endtask

    // Converter used for converter checks only, never plain connectivity
    task automatic frame(input logic [35:0] din, output logic [35:0] dout);
        adcbs_ctrl_s c;
        c = din[34:0];
        // Ten-bit DAC code, parked at midpoint while sampling
        if (!c.hold) c.dac_code = 10'h200;
        // Hold raised only with the analog clock high when gains run
        if (c.gain_stage_power_on && c.hold) c.aclk = 1'b1;
        // One-hot input select, idle bit 0
        if (!$onehot(c.input_select)) c.input_select = 8'h01;
        din[34:0] = c;
        capture <= 1'b1;
        pulse();
        capture <= 1'b0;
        shift <= 1'b1;
        for (int i = 0; i < 36; i++) begin
            tdi <= din[i];
            tick(1);
            tck <= 1'b1;
            // TDO settles 3-4 clocks after the fall, so sample mid-high
            tick(2);
            dout[i] = tdo;
            tick(2);
            tck <= 1'b0;
            tick(3);
        end
        shift <= 1'b0;
        update <= 1'b1;
        pulse();
        update <= 1'b0;
        tdi <= ~din[35];
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench of the converter scan control block
// Assumes: 10 MHz system clock, register bus driven as Avalon master
// Notes: Scan frames come from the controller model
`timescale 1ns/10ps
`default_nettype none
`include "adcbs_map.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb
    import adcbs_pkg::*;
;
    logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest, cmp_result;
    logic tck, tdi, capture, shift, update, tdo, adc_ready, cmp_observed;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [35:0] so;
    adcbs_ctrl_s adc_ctrl, idle, pat;
    int bad_count = 0;
    int n_checks = 0;

    adcbs_scan_ctrl #(.CMP_DIV(1), .SETTLE_CYC(2)) adcbs_scan_ctrl_i (
        .CLK_SYS(clk_sys), .RESETN(resetn), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .TAP_TCK(tck), .TAP_TDI(tdi),
        .TAP_CAPTURE(capture), .TAP_SHIFT(shift), .TAP_UPDATE(update), .TAP_TDO(tdo),
        .CMP_RESULT(cmp_result), .ADC_CTRL(adc_ctrl), .ADC_READY(adc_ready),
        .CMP_OBSERVED(cmp_observed));

    adcbs_tap_model adcbs_tap_model_i (.clk(clk_sys), .tck(tck), .tdi(tdi),
        .capture(capture), .shift(shift), .update(update), .tdo(tdo));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Waits as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0);
        `CHK("bus answer cycles", 2, n)
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic t_idle;
        cmp_result <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("idle lines", idle, adc_ctrl)
        `CHK("idle lines", idle, adc_ctrl)
        `CHK("cmp unpowered", 1'b0, cmp_observed)
        `CHK("ready off", 1'b0, adc_ready)
        av(1'b0, `ADCBS_REG_FUNC_LO, '0);
        `CHK("func lo", idle[31:0], rd)
        av(1'b0, `ADCBS_REG_FUNC_HI, '0);
        `CHK("func hi", {29'h0, idle[34:32]}, rd)
        av(1'b1, 5'h18, 32'hffff_ffff);
        av(1'b0, 5'h18, '0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("unmapped write", idle, adc_ctrl)
        $display("t_idle done");
    endtask

    task automatic t_gain;
        pat = idle;
        pat.gain_x10_en = 1'b1;
        pat.gain_x20_en = 1'b1;
        av(1'b1, `ADCBS_REG_FUNC_LO, pat[31:0]);
        repeat (3) @(posedge clk_sys);
        `CHK("both gains", idle, adc_ctrl)
        pat.gain_x20_en = 1'b0;
        av(1'b1, `ADCBS_REG_FUNC_LO, pat[31:0]);
        repeat (3) @(posedge clk_sys);
        `CHK("tenfold gain", pat, adc_ctrl)
        av(1'b1, `ADCBS_REG_FUNC_LO, idle[31:0]);
        pat = idle;
        pat.aclk = 1'b1;
        pat.gain_path_to_cmp_en = 1'b1;
        pat.bandgap_neg_input_en = 1'b1;
        av(1'b1, `ADCBS_REG_FUNC_HI, 32'h0000_0007);
        repeat (3) @(posedge clk_sys);
        `CHK("upper lines", pat, adc_ctrl)
        av(1'b1, `ADCBS_REG_FUNC_HI, 32'h0000_0000);
        $display("t_gain done");
    endtask

    task automatic t_power;
        int n;
        pat = idle;
        pat.converter_power_on = 1'b1;
        av(1'b1, `ADCBS_REG_FUNC_LO, pat[31:0]);
        n = 0;
        while (adc_ready !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("dummy floor", 1'b1, n >= 12)
        `CHK("dummy ceiling", 1'b1, n <= 16)
        `CHK("cmp powered", 1'b1, cmp_observed)
        av(1'b0, `ADCBS_REG_STATUS, '0);
        `CHK("status ready", 32'h0000_0005, rd)
        av(1'b1, `ADCBS_REG_FUNC_LO, idle[31:0]);
        repeat (3) @(posedge clk_sys);
        `CHK("ready off", 1'b0, adc_ready)
        `CHK("cmp off", 1'b0, cmp_observed)
        $display("t_power done");
    endtask

    task automatic t_scan;
        pat = idle;
        pat.converter_power_on = 1'b1;
        pat.dac_code = 10'h123;
        pat.input_select = 8'h08;
        pat.cmp_latch_precharge_n = 1'b0;
        cmp_result <= 1'b0;
        adcbs_tap_model_i.frame({1'b0, pat}, so);
        `CHK("captured idle", {1'b0, idle}, so)
        av(1'b1, `ADCBS_REG_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        `CHK("scan drive", pat, adc_ctrl)
        `CHK("scan ready", 1'b1, adc_ready)
        av(1'b0, `ADCBS_REG_APPL_LO, '0);
        `CHK("applied lo", pat[31:0], rd)
        cmp_result <= 1'b1;
        repeat (5) @(posedge clk_sys);
        adcbs_tap_model_i.frame({1'b0, idle}, so);
        `CHK("captured pattern", {1'b1, pat}, so)
        repeat (3) @(posedge clk_sys);
        `CHK("scan idle", idle, adc_ctrl)
        av(1'b1, `ADCBS_REG_CTRL, 32'h0);
        $display("t_scan done");
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        $display("CHECK FAILED watchdog expected end seen hang");
        test_done();
    end

    initial begin
        resetn = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        cmp_result = 1'b0;
        idle = '0;
        idle.dac_code = 10'h200;
        idle.gain_bypass_en = 1'b1;
        idle.hold = 1'b1;
        idle.input_select = 8'h01;
        idle.gain_passgate_en = 1'b1;
        idle.cmp_latch_precharge_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_idle();
        t_gain();
        t_power();
        t_scan();
        test_done();
    end
endmodule
`default_nettype wire
